// ==== hw/global_config_pkg.sv ====
// constants for the chip-level configuration register bank
// Notes on behaviour
// RULE1: unimplemented global indexes/bits ignore writes, read zero
// RULE2: index port selects, data port accesses, config only
// RULE3: config control bit 0 soft-resets, self-clearing
// RULE4: device number selects bank; activate hits selected
// RULE5: identification register is fixed, read-only, 8 bits
// RULE6: revision register is fixed, read-only, 8 bits
// RULE7: power control bits 0,3,4,5; others zero
// RULE8: power management bits 0,3,4,5; others zero
// RULE9: oscillator field gates oscillator and baud clock
// RULE10: clock output select bits 6:4 pick frequency
// RULE11: oscillator bit 7 sets interrupt-8 line polarity
// RULE12: polarity also sets serial irq sample level
// RULE13: device mode bit 2 enables serial irq
// RULE14: device mode bits 4:3 floppy-on-parallel routing
// RULE15: serial irq bit also gates clock-run behaviour
// RULE16: activate bit 0 activates the selected device
// RULE17: identity registers ignore writes, survive soft reset
package global_config_pkg;
  // ****************************************************************
  // register indexes
  // ****************************************************************
  localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02; // write only
  localparam logic [7:0] IDX_LOGICAL_DEVICE = 8'h07;
  localparam logic [7:0] IDX_IDENTIFICATION = 8'h20;
  localparam logic [7:0] IDX_REVISION       = 8'h21;
  localparam logic [7:0] IDX_POWER_CONTROL  = 8'h22;
  localparam logic [7:0] IDX_POWER_MGMT     = 8'h23;
  localparam logic [7:0] IDX_OSCILLATOR     = 8'h24;
  localparam logic [7:0] IDX_DEVICE_MODE    = 8'h25;
  localparam logic [7:0] IDX_ACTIVATE       = 8'h30; // per device

  // ****************************************************************
  // implemented-bit masks
  // ****************************************************************
  localparam logic [7:0] MASK_LOGICAL_DEVICE = 8'hff;
  localparam logic [7:0] MASK_FUNCTION       = 8'h39; // bits 0,3,4,5
  localparam logic [7:0] MASK_OSCILLATOR     = 8'hfc;
  localparam logic [7:0] MASK_DEVICE_MODE    = 8'h1c;
  localparam logic [7:0] MASK_ACTIVATE       = 8'h01;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SOFT_RESET_BIT   = 0;
  localparam int FUNC_FLOPPY_BIT  = 0;
  localparam int FUNC_PARALLEL    = 3;
  localparam int FUNC_SERIAL1     = 4;
  localparam int FUNC_SERIAL2     = 5;
  localparam int OSC_FIELD_LSB    = 2;
  localparam int CLK_SEL_LSB      = 4;
  localparam int IRQ8_POLARITY    = 7;
  localparam int SERIAL_IRQ_BIT   = 2;
  localparam int FLOPPY_ROUTE_LSB = 3;

  // ****************************************************************
  // field codes
  // ****************************************************************
  localparam logic [1:0] OSC_ALWAYS_ON  = 2'h0;
  localparam logic [1:0] OSC_POWER_GOOD_INPUT_A    = 2'h1;
  localparam logic [1:0] OSC_POWER_GOOD_INPUT_B    = 2'h2;
  localparam logic [1:0] OSC_ALWAYS_OFF = 2'h3;
  localparam logic [2:0] CLK_SEL_LAST   = 3'h4; // above is reserved
  localparam logic [1:0] ROUTE_FLOPPY_1 = 2'h1;
  localparam logic [1:0] ROUTE_FLOPPY_2 = 2'h2;

  // ****************************************************************
  // reset values (hard and soft alike)
  // ****************************************************************
  localparam logic [7:0] RST_LOGICAL_DEVICE = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL  = 8'h00;
  localparam logic [7:0] RST_POWER_MGMT     = 8'h00;
  localparam logic [7:0] RST_OSCILLATOR     = 8'h04; // field code 01
  localparam logic [7:0] RST_DEVICE_MODE    = 8'h04; // serial irq on
endpackage

// ==== hw/level_sync.sv ====
// two-flop synchroniser for a level arriving from a pin
`timescale 1ns/100ps
module level_sync (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  logic first_stage; // only the second flop reads this

  // two stages, nothing taps the first
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      first_stage <= 1'b0;
      sync_out    <= 1'b0;
    end else begin
      first_stage <= async_in;
      sync_out    <= first_stage;
    end
  end
endmodule

// ==== hw/oscillator_gate.sv ====
// oscillator and baud clock enables from the oscillator field
`timescale 1ns/100ps
module oscillator_gate (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // controls
  input  wire logic [1:0] osc_code_in,
  input  wire logic       power_good_in,
  // enables
  output logic            osc_enable_out,
  output logic            baud_enable_out
);
  logic next_on; // both enables follow one decision

  // decode the two-bit field
  always_comb begin
    case (osc_code_in)
      global_config_pkg::OSC_ALWAYS_ON:  next_on = 1'b1;           // [RULE9]
      global_config_pkg::OSC_POWER_GOOD_INPUT_A:    next_on = power_good_in;  // [RULE9]
      global_config_pkg::OSC_POWER_GOOD_INPUT_B:    next_on = power_good_in;  // [RULE9]
      global_config_pkg::OSC_ALWAYS_OFF: next_on = 1'b0;           // [RULE9]
      default:                           next_on = 1'b0;
    endcase
  end

  // register both enables
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      osc_enable_out  <= 1'b0;
      baud_enable_out <= 1'b0;
    end else begin
      osc_enable_out  <= next_on;
      baud_enable_out <= next_on;
    end
  end
endmodule

// ==== hw/global_config_registers.sv ====
// chip-level configuration register bank behind index and data ports
`timescale 1ns/100ps
module global_config_registers #(
  parameter int         NUM_LDEV = 16,    // logical devices with activate
  parameter logic [7:0] ID_CODE  = 8'h5a, // arbitrary identification value
  parameter logic [7:0] REV_CODE = 8'h3c  // arbitrary revision value
) (
  // clock and reset
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  // host configuration access
  input  wire logic                config_state_in,
  input  wire logic                index_write_in,
  input  wire logic                data_write_in,
  input  wire logic                data_read_in,
  input  wire logic [7:0]          write_data_in,
  output logic      [7:0]          read_data_out,
  output logic                     read_valid_out,
  // pins and peer logic
  input  wire logic                power_good_input_in,
  input  wire logic                rtc_irq_source_in,
  // soft reset and device selection
  output logic                     soft_reset_out,
  output logic      [7:0]          logical_device_out,
  output logic      [NUM_LDEV-1:0] activate_out,
  // function power, order {serial2, serial1, parallel, floppy}
  output logic      [3:0]          power_enable_out,
  output logic      [3:0]          pm_enable_out,
  // clocks
  output logic                     oscillator_enable_out,
  output logic                     baud_rate_clock_enable_out,
  output logic      [2:0]          clock_output_select_out,
  output logic                     clock_select_reserved_out,
  // interrupt 8 and serial irq
  output logic                     rtc_interrupt_line_out,
  output logic                     irq8_sample_level_out,
  output logic                     serial_irq_enable_out,
  output logic                     clock_run_enable_out,
  output logic                     dma_clock_run_enable_out,
  // floppy routing
  output logic                     floppy_on_parallel_one_out,
  output logic                     floppy_on_parallel_two_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // implemented bits per index; zero means not implemented
  function automatic logic [7:0] write_mask(input logic [7:0] idx);
    case (idx)
      global_config_pkg::IDX_LOGICAL_DEVICE: write_mask = global_config_pkg::MASK_LOGICAL_DEVICE;
      global_config_pkg::IDX_POWER_CONTROL:  write_mask = global_config_pkg::MASK_FUNCTION;
      global_config_pkg::IDX_POWER_MGMT:     write_mask = global_config_pkg::MASK_FUNCTION;
      global_config_pkg::IDX_OSCILLATOR:     write_mask = global_config_pkg::MASK_OSCILLATOR;
      global_config_pkg::IDX_DEVICE_MODE:    write_mask = global_config_pkg::MASK_DEVICE_MODE;
      global_config_pkg::IDX_ACTIVATE:       write_mask = global_config_pkg::MASK_ACTIVATE;
      default:                               write_mask = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]          index_reg;        // selected register index
  logic [7:0]          logical_device;   // current bank
  logic [7:0]          power_control;    // function power bits
  logic [7:0]          power_mgmt;       // power management bits
  logic [7:0]          oscillator;       // oscillator and clock bits
  logic [7:0]          device_mode;      // serial irq and routing
  logic [NUM_LDEV-1:0] activate;         // one bit per device
  logic [7:0]          read_value;       // mux ahead of read flop
  logic                data_write;       // qualified data write
  logic                soft_hit;         // soft reset this cycle
  logic [7:0]          wr_mask;          // mask for current index
  logic                power_good;       // synchronised power good
  logic                selected_active;  // activate bit of bank

  // ****************************************************************
  // access qualification
  // ****************************************************************

  // ports only act inside the configuration state
  // reads are not gated here; the read flop answers zero instead
  assign data_write = config_state_in && data_write_in;            // [RULE2]
  assign wr_mask    = write_mask(index_reg);                       // [RULE1]

  // soft reset applies in the cycle of the write itself, so no later
  // write can collide with it; the bit is never stored
  assign soft_hit = data_write                                     // [RULE3]
                 && (index_reg == global_config_pkg::IDX_CONFIG_CONTROL)
                 && write_data_in[global_config_pkg::SOFT_RESET_BIT];

  // index port
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      index_reg <= 8'h00;
    end else if (config_state_in && index_write_in) begin         // [RULE2]
      index_reg <= write_data_in;
    end
  end

  // ****************************************************************
  // global registers
  // ****************************************************************

  // logical device number
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      logical_device <= global_config_pkg::RST_LOGICAL_DEVICE;
    end else if (soft_hit) begin                                   // [RULE3]
      logical_device <= global_config_pkg::RST_LOGICAL_DEVICE;
    end else if (data_write
                 && index_reg == global_config_pkg::IDX_LOGICAL_DEVICE) begin
      logical_device <= write_data_in & wr_mask;                   // [RULE4]
    end
  end

  // function power control
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      power_control <= global_config_pkg::RST_POWER_CONTROL;
    end else if (soft_hit) begin                                   // [RULE3]
      power_control <= global_config_pkg::RST_POWER_CONTROL;
    end else if (data_write
                 && index_reg == global_config_pkg::IDX_POWER_CONTROL) begin
      power_control <= write_data_in & wr_mask;                    // [RULE7]
    end
  end

  // function power management
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      power_mgmt <= global_config_pkg::RST_POWER_MGMT;
    end else if (soft_hit) begin                                   // [RULE3]
      power_mgmt <= global_config_pkg::RST_POWER_MGMT;
    end else if (data_write
                 && index_reg == global_config_pkg::IDX_POWER_MGMT) begin
      power_mgmt <= write_data_in & wr_mask;                       // [RULE8]
    end
  end

  // oscillator, clock output select, interrupt 8 polarity
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      oscillator <= global_config_pkg::RST_OSCILLATOR;
    end else if (soft_hit) begin                                   // [RULE3]
      oscillator <= global_config_pkg::RST_OSCILLATOR;
    end else if (data_write
                 && index_reg == global_config_pkg::IDX_OSCILLATOR) begin
      // reserved select codes are stored and flagged, not refused
      oscillator <= write_data_in & wr_mask;                       // [RULE1]
    end
  end

  // device mode
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      device_mode <= global_config_pkg::RST_DEVICE_MODE;
    end else if (soft_hit) begin                                   // [RULE3]
      device_mode <= global_config_pkg::RST_DEVICE_MODE;
    end else if (data_write
                 && index_reg == global_config_pkg::IDX_DEVICE_MODE) begin
      device_mode <= write_data_in & wr_mask;                      // [RULE14]
    end
  end

  // ****************************************************************
  // per-device activate bits
  // ****************************************************************

  // only the bank named by the device number takes the write; a number
  // beyond the bank count hits nothing
  genvar dev;
  generate
    for (dev = 0; dev < NUM_LDEV; dev++) begin : g_activate
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          activate[dev] <= 1'b0;
        end else if (soft_hit) begin                               // [RULE3]
          activate[dev] <= 1'b0;
        end else if (data_write
                     && index_reg == global_config_pkg::IDX_ACTIVATE
                     && logical_device == 8'(dev)) begin           // [RULE4]
          activate[dev] <= write_data_in[0];                       // [RULE16]
        end
      end
    end
  endgenerate

  // activate bit of the selected bank, zero when out of range
  // a compare loop rather than an index, so an out-of-range number
  // can never select past the end of the vector
  always_comb begin
    selected_active = 1'b0;
    for (int i = 0; i < NUM_LDEV; i++) begin
      if (logical_device == 8'(i)) begin
        selected_active = activate[i];                             // [RULE16]
      end
    end
  end

  // ****************************************************************
  // data port reads
  // ****************************************************************

  // identity codes are constants: no write path, no soft reset
  always_comb begin
    case (index_reg)
      global_config_pkg::IDX_IDENTIFICATION: read_value = ID_CODE;  // [RULE5] [RULE17]
      global_config_pkg::IDX_REVISION:       read_value = REV_CODE; // [RULE6] [RULE17]
      global_config_pkg::IDX_LOGICAL_DEVICE: read_value = logical_device & wr_mask;
      global_config_pkg::IDX_POWER_CONTROL:  read_value = power_control & wr_mask;
      global_config_pkg::IDX_POWER_MGMT:     read_value = power_mgmt & wr_mask;
      global_config_pkg::IDX_OSCILLATOR:     read_value = oscillator & wr_mask;
      global_config_pkg::IDX_DEVICE_MODE:    read_value = device_mode & wr_mask;
      global_config_pkg::IDX_ACTIVATE:       read_value = {7'h00, selected_active};
      // config control is write only and everything else is empty
      default:                               read_value = 8'h00;   // [RULE1]
    endcase
  end

  // read answer one cycle after the strobe; outside the configuration
  // state the host still gets an answer, but it is zero
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      read_data_out  <= 8'h00;
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= data_read_in;
      if (data_read_in) begin
        read_data_out <= config_state_in ? read_value : 8'h00;     // [RULE2]
      end
    end
  end

  // ****************************************************************
  // clocks
  // ****************************************************************

  // power good is a pin, so it is synchronised first
  level_sync power_good_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (power_good_input_in),
    .sync_out (power_good)
  );

  // oscillator and baud clock enables
  oscillator_gate osc_gate (
    .clock_in        (clock_in),
    .rst_in          (rst_in),
    .osc_code_in     (oscillator[global_config_pkg::OSC_FIELD_LSB +: 2]),
    .power_good_in   (power_good),
    .osc_enable_out  (oscillator_enable_out),
    .baud_enable_out (baud_rate_clock_enable_out)
  );

  // clock output select and its reserved flag
  // reserved codes are passed on flagged; the clock source decides
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      clock_output_select_out   <= 3'h0;
      clock_select_reserved_out <= 1'b0;
    end else begin
      clock_output_select_out <=                                   // [RULE10]
        oscillator[global_config_pkg::CLK_SEL_LSB +: 3];
      clock_select_reserved_out <=                                 // [RULE10]
        oscillator[global_config_pkg::CLK_SEL_LSB +: 3] > global_config_pkg::CLK_SEL_LAST;
    end
  end

  // ****************************************************************
  // registered control outputs
  // ****************************************************************

  // device selection and power bits, one cycle behind the registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      soft_reset_out     <= 1'b0;
      logical_device_out <= 8'h00;
      activate_out       <= '0;
      power_enable_out   <= 4'h0;
      pm_enable_out      <= 4'h0;
    end else begin
      soft_reset_out     <= soft_hit;                              // [RULE3]
      logical_device_out <= logical_device;                        // [RULE4]
      activate_out       <= activate;                              // [RULE16]
      power_enable_out   <= {power_control[global_config_pkg::FUNC_SERIAL2],
                             power_control[global_config_pkg::FUNC_SERIAL1],
                             power_control[global_config_pkg::FUNC_PARALLEL],
                             power_control[global_config_pkg::FUNC_FLOPPY_BIT]}; // [RULE7]
      pm_enable_out      <= {power_mgmt[global_config_pkg::FUNC_SERIAL2],
                             power_mgmt[global_config_pkg::FUNC_SERIAL1],
                             power_mgmt[global_config_pkg::FUNC_PARALLEL],
                             power_mgmt[global_config_pkg::FUNC_FLOPPY_BIT]};    // [RULE8]
    end
  end

  // interrupt 8: polarity one inverts, for the pin and the serial frame
  // both flops take the same xor so pin and frame never disagree
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rtc_interrupt_line_out <= 1'b0;
      irq8_sample_level_out  <= 1'b0;
    end else begin
      rtc_interrupt_line_out <= rtc_irq_source_in                  // [RULE11]
                              ^ oscillator[global_config_pkg::IRQ8_POLARITY];
      irq8_sample_level_out  <= rtc_irq_source_in                  // [RULE12]
                              ^ oscillator[global_config_pkg::IRQ8_POLARITY];
    end
  end

  // serial irq enable also gates clock-run and its dma influence
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      serial_irq_enable_out    <= 1'b0;
      clock_run_enable_out     <= 1'b0;
      dma_clock_run_enable_out <= 1'b0;
    end else begin
      serial_irq_enable_out    <= device_mode[global_config_pkg::SERIAL_IRQ_BIT]; // [RULE13]
      clock_run_enable_out     <= device_mode[global_config_pkg::SERIAL_IRQ_BIT]; // [RULE15]
      dma_clock_run_enable_out <= device_mode[global_config_pkg::SERIAL_IRQ_BIT]; // [RULE15]
    end
  end

  // floppy routing; the reserved code selects neither mode
  // the pair is never both high, so the port sees one mode at most
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      floppy_on_parallel_one_out <= 1'b0;
      floppy_on_parallel_two_out <= 1'b0;
    end else begin
      floppy_on_parallel_one_out <=                                // [RULE14]
        device_mode[global_config_pkg::FLOPPY_ROUTE_LSB +: 2] == global_config_pkg::ROUTE_FLOPPY_1;
      floppy_on_parallel_two_out <=                                // [RULE14]
        device_mode[global_config_pkg::FLOPPY_ROUTE_LSB +: 2] == global_config_pkg::ROUTE_FLOPPY_2;
    end
  end

endmodule

// ==== testbench/gcr_chk.sv ====
// port assertions for the global configuration register bank
`timescale 1ns/100ps
module gcr_chk (
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       config_state_in,
  input wire logic       data_read_in,
  input wire logic [7:0] read_data_out,
  input wire logic       read_valid_out,
  input wire logic       soft_reset_out,
  input wire logic [2:0] clock_output_select_out,
  input wire logic       clock_select_reserved_out,
  input wire logic       rtc_interrupt_line_out,
  input wire logic       irq8_sample_level_out,
  input wire logic       serial_irq_enable_out,
  input wire logic       clock_run_enable_out,
  input wire logic       dma_clock_run_enable_out,
  input wire logic       floppy_on_parallel_one_out,
  input wire logic       floppy_on_parallel_two_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_read_answer: assert property (data_read_in |=> read_valid_out)
    else $error("read not answered");
  a_no_stray: assert property (!data_read_in |=> !read_valid_out)
    else $error("stray read valid");
  a_closed_zero: assert property (
    !config_state_in && data_read_in |=> read_data_out == 8'h00)
    else $error("read outside config state not zero");
  a_soft_self_clear: assert property (
    soft_reset_out |=> !soft_reset_out && serial_irq_enable_out)
    else $error("soft reset pulse wrong");
  a_clk_reserved: assert property (
    clock_select_reserved_out == (clock_output_select_out > global_config_pkg::CLK_SEL_LAST))
    else $error("reserved clock code flag wrong");
  a_irq8_sample: assert property (irq8_sample_level_out == rtc_interrupt_line_out)
    else $error("sample level differs from line");
  a_serirq_trio: assert property (serial_irq_enable_out == clock_run_enable_out &&
    serial_irq_enable_out == dma_clock_run_enable_out) else $error("clock run mismatch");
  a_route_excl: assert property (
    !(floppy_on_parallel_one_out && floppy_on_parallel_two_out))
    else $error("both floppy routes on");
endmodule
bind global_config_registers gcr_chk i_gcr_chk (.*);

// ==== testbench/host_model.sv ====
// host side: index then data configuration cycles
`timescale 1ns/100ps
module host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] read_data_out,
  input  wire logic       read_valid_out,
  output logic            config_state_in,
  output logic            index_write_in,
  output logic            data_write_in,
  output logic            data_read_in,
  output logic [7:0]      write_data_in
);
  initial {config_state_in, index_write_in, data_write_in, data_read_in} = 4'h8;
  initial write_data_in = 8'h00;
  task automatic tick;
    @(posedge clock_in);
    #1;
  endtask
  // a read's data phase shows the inverse of the index, never a stale value
  task automatic wr(input logic [7:0] a, v);
    index_write_in = 1'b1;
    write_data_in = a;
    tick;
    index_write_in = 1'b0;
    data_write_in = 1'b1;
    write_data_in = v;
    tick;
    data_write_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
    index_write_in = 1'b1;
    write_data_in = a;
    tick;
    index_write_in = 1'b0;
    write_data_in = ~a;
    data_read_in = 1'b1;
    tick;
    data_read_in = 1'b0;
    ok = read_valid_out;
    v = read_data_out;
  endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the global configuration register bank
`timescale 1ns/100ps
module tb;
  logic clock_in, rst_in, power_good_input_in, rtc_irq_source_in, config_state_in;
  logic index_write_in, data_write_in, data_read_in, read_valid_out, soft_reset_out;
  logic oscillator_enable_out, baud_rate_clock_enable_out, clock_select_reserved_out;
  logic rtc_interrupt_line_out, irq8_sample_level_out, serial_irq_enable_out;
  logic clock_run_enable_out, dma_clock_run_enable_out;
  logic floppy_on_parallel_one_out, floppy_on_parallel_two_out;
  logic [7:0] write_data_in, read_data_out, logical_device_out;
  logic [15:0] activate_out;
  logic [3:0] power_enable_out, pm_enable_out;
  logic [2:0] clock_output_select_out;
  int err_total, cmp_count;
  // identity values are arbitrary
  global_config_registers #(.ID_CODE(8'h6b), .REV_CODE(8'h2d)) i_global_config_registers (.*);
  host_model i_host_model (.*);
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic cmp(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, e);
    logic [7:0] v;
    logic ok;
    i_host_model.rd(a, v, ok);
    cmp({7'h0, ok, v}, {8'h01, e});
  endtask
  task automatic t_regs;
    logic [7:0] ta[8] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h01, 8'h20, 8'h21, 8'h2f};
    logic [7:0] te[8] = '{8'h39, 8'h39, 8'hfc, 8'h1c, 8'h00, 8'h6b, 8'h2d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      chk(ta[i], (i == 2 || i == 3) ? 8'h04 : (i > 4 ? te[i] : 8'h00));
      i_host_model.wr(ta[i], (i == 5) ? 8'h00 : 8'hff);
      chk(ta[i], te[i]);
    end
    cmp({power_enable_out, pm_enable_out}, 16'h00ff);
    $display("register masks done");
  endtask
  task automatic t_osc;
    logic e;
    for (int i = 0; i < 8; i++) begin
      power_good_input_in = i[2];
      rtc_irq_source_in = i[1];
      i_host_model.wr(8'h24, {i[0], i[2:0], i[1:0], 2'b00});
      repeat (4) i_host_model.tick;
      e = (i[1:0] == 2'h0) ? 1'b1 : ((i[1:0] == 2'h3) ? 1'b0 : i[2]);
      cmp({oscillator_enable_out, baud_rate_clock_enable_out, rtc_interrupt_line_out,
        irq8_sample_level_out, clock_select_reserved_out, clock_output_select_out},
        {e, e, i[1] ^ i[0], i[1] ^ i[0], i > 4, i[2:0]});
    end
    $display("oscillator codes done");
  endtask
  task automatic t_mode;
    for (int j = 0; j < 4; j++) begin
      i_host_model.wr(8'h25, {3'b000, j[1:0], j[0], 2'b00});
      i_host_model.tick;
      cmp({serial_irq_enable_out, clock_run_enable_out, dma_clock_run_enable_out,
        floppy_on_parallel_one_out, floppy_on_parallel_two_out},
        {j[0], j[0], j[0], j == 1, j == 2});
    end
    $display("device modes done");
  endtask
  task automatic t_act;
    i_host_model.wr(8'h07, 8'h03);
    i_host_model.wr(8'h30, 8'h01);
    i_host_model.tick;
    cmp({logical_device_out, activate_out[7:0]}, 16'h0308);
    i_host_model.wr(8'h07, 8'h05);
    chk(8'h30, 8'h00);
    $display("activate done");
  endtask
  task automatic t_soft;
    i_host_model.wr(8'h02, 8'h01);
    cmp({15'h0000, soft_reset_out}, 16'h0001);
    chk(8'h22, 8'h00);
    chk(8'h20, 8'h6b);
    cmp(activate_out, 16'h0000);
    i_host_model.config_state_in = 1'b0;
    i_host_model.wr(8'h22, 8'hff);
    chk(8'h22, 8'h00);
    i_host_model.config_state_in = 1'b1;
    chk(8'h22, 8'h00);
    $display("soft reset and config gate done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
  initial begin
    {rst_in, power_good_input_in, rtc_irq_source_in} = 3'b100;
    repeat (20) @(posedge clock_in);
    #1 rst_in = 1'b0;
    t_regs;
    t_osc;
    t_mode;
    t_act;
    t_soft;
    report_and_stop;
  end
endmodule
